// file: hw/gas_pkg.sv
// Constants, types and helper functions shared by the gas alarm threshold logic.
package gas_pkg;
  localparam int DATA_W    = 16;
  localparam int NUM_CH    = 3;
  localparam int DWELL_W   = 8;
  localparam int NV_W      = 8;
  localparam int CLK_NS    = 10;
  localparam int CLK_HZ    = 100_000_000;
  // Seconds tick, completion message and serial bit time.
  localparam int SEC_S     = 1;
  localparam int SEC_CYC   = SEC_S * 1_000_000_000 / CLK_NS;
  localparam int MSG_S     = 2;
  localparam int MSG_CYC   = MSG_S * SEC_CYC;
  localparam int BAUD_BPS  = 9600;
  localparam int BIT_CYC   = CLK_HZ / BAUD_BPS;
  localparam int SEC_W     = 27;
  localparam int MSG_W     = 28;
  localparam int BIT_W     = 14;
  localparam int FRAME_W   = 11;
  // Factory thresholds as percent of full scale.
  localparam logic [6:0] PCT_CH0 = 7'd20;
  localparam logic [6:0] PCT_CH1 = 7'd40;
  localparam logic [6:0] PCT_CH2 = 7'd50;
  localparam logic [DWELL_W-1:0] DWELL_DEF = 8'h01;
  // Fault limits.
  localparam logic [DATA_W-1:0] ADC_MIN = 16'h0010;
  localparam logic [DATA_W-1:0] ADC_MAX = 16'hFFEF;
  localparam int SUPPLY_MIN_V = 10;
  localparam logic [DATA_W-1:0] SUPPLY_MIN_MV = 16'(SUPPLY_MIN_V * 1000);
  localparam logic [3:0] HUNT_LIMIT = 4'h6;
  // Fault flag positions.
  localparam int F02 = 0;
  localparam int F03 = 1;
  localparam int F04 = 2;
  localparam int F05 = 3;
  localparam int F08 = 4;
  localparam int NUM_F = 5;
  typedef enum logic {TX_IDLE, TX_SEND} tx_state_t;

  function automatic logic [DATA_W-1:0] pct_of(input logic [DATA_W-1:0] hs,
                                               input logic [6:0] pct);
    logic [22:0] p;
    p = hs * pct;
    pct_of = 16'(p / 23'd100);
  endfunction

  function automatic logic [DATA_W-1:0] clamp(input logic [DATA_W-1:0] v,
                                              input logic [DATA_W-1:0] hs);
    clamp = (v > hs) ? hs : v;
  endfunction
endpackage

// file: hw/alarm_channel.sv
// One alarm channel: direction, dead band, dwell, latch and contact drive.
`timescale 1ns/100ps
module alarm_channel (
  // Clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  // Timing
  input  wire logic                          sec_tick_i,
  input  wire logic                          blink_phase_i,
  // Measurement and settings
  input  wire logic [gas_pkg::DATA_W-1:0]    gas_i,
  input  wire logic [gas_pkg::DATA_W-1:0]    thr_i,
  input  wire logic [gas_pkg::DATA_W-1:0]    deadband_i,
  input  wire logic [gas_pkg::DWELL_W-1:0]   dwell_i,
  input  wire logic                          low_side_trip_i,
  input  wire logic                          latch_i,
  input  wire logic                          reset_key_i,
  input  wire logic                          contact_en_i,
  input  wire logic                          blink_en_i,
  input  wire logic                          buzzer_i,
  // Results
  output logic                               alarm_o,
  output logic                               contact_o
);
  logic [gas_pkg::DWELL_W:0]   dwell_q;
  logic [gas_pkg::DATA_W:0]    high_lvl;
  logic [gas_pkg::DATA_W-1:0]  low_lvl;
  logic                        cond;
  logic                        dwell_done;
  logic                        blink_gate;

  assign high_lvl   = {1'b0, thr_i} + {1'b0, deadband_i};
  assign low_lvl    = (thr_i > deadband_i) ? thr_i - deadband_i : '0;
  assign cond       = low_side_trip_i ? (gas_i <= low_lvl)
                                      : ({1'b0, gas_i} >= high_lvl);
  assign dwell_done = cond && (dwell_i == '0 || dwell_q > {1'b0, dwell_i});
  // Blink only applies while the contact is enabled and the buzzer sounds.
  assign blink_gate = (blink_en_i && buzzer_i) ? blink_phase_i : 1'b1;

  // Ticks run free, so the first one may land just after the condition rises: the count
  // must exceed the dwell to span whole seconds. The spare bit keeps saturation above it.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dwell_q <= '0;
    end else if (!cond) begin
      dwell_q <= '0;
    end else if (sec_tick_i && dwell_q != '1) begin
      dwell_q <= dwell_q + 1'b1;
    end
  end

  // A new trip wins over a release in the same cycle.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      alarm_o <= 1'b0;
    end else if (dwell_done) begin
      alarm_o <= 1'b1;
    end else if (!cond && (!latch_i || reset_key_i)) begin
      alarm_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      contact_o <= 1'b0;
    end else begin
      contact_o <= contact_en_i && alarm_o && blink_gate;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_contact_off: assert property (!contact_en_i |=> !contact_o)
    else $error("contact driven while contact output is off");
  a_dwell_reset: assert property (!cond |=> dwell_q == '0)
    else $error("dwell count not cleared when condition dropped");
  a_dwell_held: assert property ($rose(alarm_o) |-> $past(cond) &&
                                 ($past(dwell_i) == '0 || $past(dwell_q) > $past(dwell_i)))
    else $error("alarm rose before dwell time elapsed");
  a_auto_release: assert property (alarm_o && !latch_i && !cond && !dwell_done |=> !alarm_o)
    else $error("unlatched alarm did not release");
  a_latch_hold: assert property (alarm_o && latch_i && !reset_key_i |=> alarm_o)
    else $error("latched alarm released without reset key");
endmodule

// file: hw/gas_alarm_threshold_logic.sv
// Top of the gas alarm threshold logic: thresholds, channels, faults and status link.
// Notes on behaviour
// - Each alarm threshold is clamped to the configured high scale value.
// - Factory initialization loads thresholds of 20, 40 and 50 percent of scale.
// - High-side trip asserts when gas is equal to or above the threshold.
// - Low-side trip asserts when gas is equal to or below the threshold.
// - High-side trips at threshold plus dead band and releases below it.
// - Low-side trips at threshold minus dead band and releases above it.
// - An alarm trips only after its condition held for the dwell seconds.
// - A contact is never driven while its contact output setting is off.
// - With blink on, the contact toggles each second while the buzzer sounds.
// - Blink only acts when the contact output setting is also on.
// - After configuration the completion message stands for two seconds.
// - Three independent channels each have their own threshold, dwell and output settings; the latch type, reset key and buzzer are shared.
// - Unlatched alarms clear themselves; latched ones wait for the reset key.
// - Codes above the ADC maximum raise fault 02, below the minimum fault 03.
// - A parameter storage checksum mismatch raises fault 04.
// - A main supply reading below 10 V raises fault 05.
// - Repeated hunting of the gas measurement raises fault 08.
// - The serial link uses 9600 bps, eight data bits, even parity, one stop.
`timescale 1ns/100ps
module gas_alarm_threshold_logic #(
  parameter int SEC_CYC = gas_pkg::SEC_CYC,
  parameter int MSG_CYC = gas_pkg::MSG_CYC,
  parameter int BIT_CYC = gas_pkg::BIT_CYC
) (
  // Clock and reset
  input  wire logic                                         clk_i,
  input  wire logic                                         rst_i,
  // Measurement
  input  wire logic [gas_pkg::DATA_W-1:0]                   gas_i,
  input  wire logic                                         gas_valid_i,
  input  wire logic [gas_pkg::DATA_W-1:0]                   adc_code_i,
  input  wire logic [gas_pkg::DATA_W-1:0]                   supply_mv_i,
  input  wire logic [gas_pkg::DATA_W-1:0]                   high_scale_i,
  // Configuration
  input  wire logic                                         factory_init_i,
  input  wire logic                                         cfg_we_i,
  input  wire logic [1:0]                                   cfg_ch_i,
  input  wire logic [gas_pkg::DATA_W-1:0]                   cfg_thr_i,
  input  wire logic [gas_pkg::DWELL_W-1:0]                  cfg_dwell_i,
  input  wire logic                                         cfg_done_i,
  input  wire logic [gas_pkg::NUM_CH-1:0]                   low_side_trip_i,
  input  wire logic [gas_pkg::NUM_CH-1:0][gas_pkg::DATA_W-1:0] deadband_i,
  input  wire logic [gas_pkg::NUM_CH-1:0]                   contact_en_i,
  input  wire logic [gas_pkg::NUM_CH-1:0]                   blink_en_i,
  input  wire logic                                         alarm_latch_type_i,
  input  wire logic                                         reset_key_i,
  input  wire logic                                         buzzer_i,
  // Parameter storage check
  input  wire logic                                         nv_valid_i,
  input  wire logic                                         nv_last_i,
  input  wire logic [gas_pkg::NV_W-1:0]                     nv_word_i,
  input  wire logic [gas_pkg::NV_W-1:0]                     nv_sum_i,
  // Status link
  input  wire logic                                         tx_start_i,
  output logic                                              tx_o,
  output logic                                              tx_en_o,
  // Results
  output logic [gas_pkg::NUM_CH-1:0]                        alarm_o,
  output logic [gas_pkg::NUM_CH-1:0]                        contact_o,
  output logic [gas_pkg::NUM_F-1:0]                         fault_o,
  output logic                                              msg_done_o
);
  // Seconds divider and blink phase.
  logic [gas_pkg::SEC_W-1:0] sec_q;
  logic                      sec_tick;
  logic                      blink_q;

  assign sec_tick = (sec_q == gas_pkg::SEC_W'(SEC_CYC - 1));

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sec_q   <= '0;
      blink_q <= 1'b1;
    end else begin
      sec_q   <= sec_tick ? '0 : sec_q + 1'b1;
      blink_q <= sec_tick ? !blink_q : blink_q;
    end
  end

  // Threshold and dwell storage, one entry per channel.
  logic [gas_pkg::DATA_W-1:0]  thr_q   [gas_pkg::NUM_CH];
  logic [gas_pkg::DWELL_W-1:0] dwell_q [gas_pkg::NUM_CH];
  logic [6:0]                  pct     [gas_pkg::NUM_CH];

  assign pct[0] = gas_pkg::PCT_CH0;
  assign pct[1] = gas_pkg::PCT_CH1;
  assign pct[2] = gas_pkg::PCT_CH2;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < gas_pkg::NUM_CH; i++) begin
        thr_q[i]   <= '0;
        dwell_q[i] <= gas_pkg::DWELL_DEF;
      end
    end else if (factory_init_i) begin
      for (int i = 0; i < gas_pkg::NUM_CH; i++) begin
        thr_q[i]   <= gas_pkg::pct_of(high_scale_i, pct[i]);
        dwell_q[i] <= gas_pkg::DWELL_DEF;
      end
    end else if (cfg_we_i && cfg_ch_i < 2'(gas_pkg::NUM_CH)) begin
      thr_q[cfg_ch_i]   <= gas_pkg::clamp(cfg_thr_i, high_scale_i);
      dwell_q[cfg_ch_i] <= cfg_dwell_i;
    end
  end

  // The scale may be lowered after a threshold was set, so clamp again on use.
  logic [gas_pkg::DATA_W-1:0] thr_eff [gas_pkg::NUM_CH];

  for (genvar g = 0; g < gas_pkg::NUM_CH; g++) begin : g_ch
    assign thr_eff[g] = gas_pkg::clamp(thr_q[g], high_scale_i);
    alarm_channel u_ch (
      .clk_i          (clk_i),
      .rst_i          (rst_i),
      .sec_tick_i     (sec_tick),
      .blink_phase_i  (blink_q),
      .gas_i          (gas_i),
      .thr_i          (thr_eff[g]),
      .deadband_i     (deadband_i[g]),
      .dwell_i        (dwell_q[g]),
      .low_side_trip_i(low_side_trip_i[g]),
      .latch_i        (alarm_latch_type_i),
      .reset_key_i    (reset_key_i),
      .contact_en_i   (contact_en_i[g]),
      .blink_en_i     (blink_en_i[g]),
      .buzzer_i       (buzzer_i),
      .alarm_o        (alarm_o[g]),
      .contact_o      (contact_o[g])
    );
  end

  // Completion message timer; a new completion restarts the full period.
  logic [gas_pkg::MSG_W-1:0] msg_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      msg_q      <= '0;
      msg_done_o <= 1'b0;
    end else if (cfg_done_i) begin
      msg_q      <= gas_pkg::MSG_W'(MSG_CYC - 1);
      msg_done_o <= 1'b1;
    end else if (msg_q != '0) begin
      msg_q      <= msg_q - 1'b1;
    end else begin
      msg_done_o <= 1'b0;
    end
  end

  // Hunting: count direction reversals of the gas value within each second.
  logic [gas_pkg::DATA_W-1:0] last_gas_q;
  logic                       rising_q;
  logic                       dir_known_q;
  logic [3:0]                 rev_q;
  logic                       hunt_q;
  logic                       moved;
  logic                       going_up;
  logic                       reversal;

  assign moved    = gas_valid_i && (gas_i != last_gas_q);
  assign going_up = gas_i > last_gas_q;
  assign reversal = moved && dir_known_q && (going_up != rising_q);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      last_gas_q  <= '0;
      rising_q    <= 1'b0;
      dir_known_q <= 1'b0;
    end else if (moved) begin
      last_gas_q  <= gas_i;
      rising_q    <= going_up;
      dir_known_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rev_q  <= '0;
      hunt_q <= 1'b0;
    end else if (sec_tick) begin
      rev_q  <= '0;
      hunt_q <= (rev_q >= gas_pkg::HUNT_LIMIT);
    end else if (reversal && rev_q != '1) begin
      rev_q  <= rev_q + 1'b1;
      hunt_q <= hunt_q || (rev_q + 1'b1 >= gas_pkg::HUNT_LIMIT);
    end
  end

  // Storage checksum: 8-bit sum over the block, compared at its last word.
  logic [gas_pkg::NV_W-1:0] nv_sum_q;
  logic [gas_pkg::NV_W-1:0] nv_sum_d;
  logic                     nv_bad_q;

  assign nv_sum_d = nv_sum_q + nv_word_i;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      nv_sum_q <= '0;
      nv_bad_q <= 1'b0;
    end else if (nv_valid_i) begin
      nv_sum_q <= nv_last_i ? '0 : nv_sum_d;
      nv_bad_q <= nv_last_i ? (nv_sum_d != nv_sum_i) : nv_bad_q;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fault_o <= '0;
    end else begin
      fault_o[gas_pkg::F02] <= adc_code_i > gas_pkg::ADC_MAX;
      fault_o[gas_pkg::F03] <= adc_code_i < gas_pkg::ADC_MIN;
      fault_o[gas_pkg::F04] <= nv_bad_q;
      fault_o[gas_pkg::F05] <= supply_mv_i < gas_pkg::SUPPLY_MIN_MV;
      fault_o[gas_pkg::F08] <= hunt_q;
    end
  end

  // Status byte transmitter, 8E1 framing, LSB first.
  // Starts that arrive while a frame is on the line are dropped rather than queued.
  localparam gas_pkg::tx_state_t TX_IDLE_C = gas_pkg::TX_IDLE;
  gas_pkg::tx_state_t              tx_st_q;
  logic [gas_pkg::FRAME_W-1:0]     frame_q;
  logic [3:0]                      nbit_q;
  logic [gas_pkg::BIT_W-1:0]       baud_q;
  logic [7:0]                      status;
  logic                            bit_end;

  assign status  = {4'h0, |fault_o, alarm_o};
  assign bit_end = (baud_q == gas_pkg::BIT_W'(BIT_CYC - 1));

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_st_q <= TX_IDLE_C;
      frame_q <= '1;
      nbit_q  <= '0;
      baud_q  <= '0;
      tx_o    <= 1'b1;
      tx_en_o <= 1'b0;
    end else begin
      case (tx_st_q)
        gas_pkg::TX_IDLE: begin
          if (tx_start_i) begin
            frame_q <= {1'b1, ^status, status, 1'b0};
            nbit_q  <= '0;
            baud_q  <= '0;
            tx_o    <= 1'b0;
            tx_en_o <= 1'b1;
            tx_st_q <= gas_pkg::TX_SEND;
          end
        end
        gas_pkg::TX_SEND: begin
          baud_q <= bit_end ? '0 : baud_q + 1'b1;
          if (bit_end) begin
            if (nbit_q == 4'(gas_pkg::FRAME_W - 1)) begin
              tx_o    <= 1'b1;
              tx_en_o <= 1'b0;
              tx_st_q <= gas_pkg::TX_IDLE;
            end else begin
              frame_q <= {1'b1, frame_q[gas_pkg::FRAME_W-1:1]};
              tx_o    <= frame_q[1];
              nbit_q  <= nbit_q + 1'b1;
            end
          end
        end
        default: tx_st_q <= gas_pkg::TX_IDLE;
      endcase
    end
  end

  // Helper for the message length check.
  logic [gas_pkg::MSG_W-1:0] msg_len_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      msg_len_q <= '0;
    end else begin
      msg_len_q <= (cfg_done_i || !msg_done_o) ? '0 : msg_len_q + 1'b1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_start_low;
    (!tx_o && tx_en_o)[*8];
  endsequence

  a_factory_load: assert property (factory_init_i |=> thr_q[1] == gas_pkg::pct_of($past(high_scale_i), 7'd40))
    else $error("factory threshold for second alarm wrong");
  a_thr_clamped: assert property (cfg_we_i && !factory_init_i && cfg_ch_i == 2'd0 |=> thr_q[0] <= $past(high_scale_i))
    else $error("stored threshold above high scale");
  a_msg_length: assert property ($fell(msg_done_o) |-> msg_len_q == gas_pkg::MSG_W'(MSG_CYC))
    else $error("completion message length wrong");
  a_fault_supply: assert property (supply_mv_i < gas_pkg::SUPPLY_MIN_MV |=> fault_o[gas_pkg::F05])
    else $error("low supply fault missing");
  a_fault_adc: assert property (adc_code_i > gas_pkg::ADC_MAX |=> fault_o[gas_pkg::F02] && !fault_o[gas_pkg::F03])
    else $error("ADC over-range fault wrong");
  a_tx_start: assert property (tx_start_i && tx_st_q == gas_pkg::TX_IDLE |=> s_start_low)
    else $error("start bit not driven");
  a_tx_stop: assert property ($fell(tx_en_o) |-> tx_o && $past(tx_o))
    else $error("frame did not end with stop bit");
endmodule

// file: test/serial_rx_model.sv
// Behavioural receiver for the status frames on the RS-485 line.
`timescale 1ns/100ps
module serial_rx_model #(
  parameter int BIT_CYC = 8
) (
  // Line
  input  wire logic       clk_i,
  input  wire logic       tx_i,
  input  wire logic       tx_en_i,
  // Decoded frame
  output logic [7:0]      byte_o,
  output logic            valid_o,
  output logic            bad_o
);
  logic [10:0] frm;
  initial begin
    valid_o = 1'b0;
    bad_o   = 1'b0;
    byte_o  = 8'h00;
    forever begin
      @(posedge clk_i);
      if (tx_en_i === 1'b1 && tx_i === 1'b0) begin
        // Sampling mid-bit tolerates a half-bit skew of the start detection.
        repeat (BIT_CYC / 2) @(posedge clk_i);
        for (int i = 0; i < 11; i++) begin
          frm[i] = tx_i;
          if (i < 10) repeat (BIT_CYC) @(posedge clk_i);
        end
        if (frm[0] !== 1'b0 || frm[10] !== 1'b1 || ^frm[9:1] !== 1'b0 || tx_en_i !== 1'b1) begin
          bad_o <= 1'b1;
        end
        byte_o  <= frm[8:1];
        valid_o <= 1'b1;
        @(posedge clk_i);
        valid_o <= 1'b0;
      end
    end
  end
endmodule

// file: test/testbench.sv
// Self-checking bench for the gas alarm threshold logic.
`timescale 1ns/100ps
module testbench;
  localparam int SC = 20;
  localparam int BC = 8;
  localparam int TW = 2 * SC + 4;
  logic            clk_i, rst_i, gv, fi, we, done, latch, rkey, buzz;
  logic            nv_valid, nv_last, tx_start, tx, tx_en, msg, rx_valid, rx_bad;
  logic [15:0]     gas, adc, sup, hs;
  logic [7:0]      nv_word, nv_sum, rx_byte;
  logic [2:0]      low, cen, ben, alarm, contact;
  logic [2:0][15:0] db;
  logic [4:0]      fault;
  logic [31:0]     rs;
  logic [7:0]      exp_q[$];
  int              fail_count, check_count, hi;
  logic [15:0]     av [5] = '{16'hFFF0, 16'hFFEF, 16'h000F, 16'h0010, 16'h8000};
  logic [15:0]     sv [5] = '{16'h5DC0, 16'h5DC0, 16'h5DC0, 16'h2710, 16'h270F};
  logic [4:0]      fv [5] = '{5'h01, 5'h00, 5'h02, 5'h00, 5'h08};
  logic [1:0]      ch;
  logic [15:0]     thr;
  logic [7:0]      dwell;

  gas_alarm_threshold_logic #(.SEC_CYC(SC), .MSG_CYC(2 * SC), .BIT_CYC(BC)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .gas_i(gas), .gas_valid_i(gv), .adc_code_i(adc),
    .supply_mv_i(sup), .high_scale_i(hs), .factory_init_i(fi), .cfg_we_i(we),
    .cfg_ch_i(ch), .cfg_thr_i(thr), .cfg_dwell_i(dwell), .cfg_done_i(done),
    .low_side_trip_i(low), .deadband_i(db), .contact_en_i(cen), .blink_en_i(ben),
    .alarm_latch_type_i(latch), .reset_key_i(rkey), .buzzer_i(buzz), .nv_valid_i(nv_valid),
    .nv_last_i(nv_last), .nv_word_i(nv_word), .nv_sum_i(nv_sum), .tx_start_i(tx_start),
    .tx_o(tx), .tx_en_o(tx_en), .alarm_o(alarm), .contact_o(contact), .fault_o(fault),
    .msg_done_o(msg));

  serial_rx_model #(.BIT_CYC(BC)) i_rx (.clk_i(clk_i), .tx_i(tx), .tx_en_i(tx_en),
    .byte_o(rx_byte), .valid_o(rx_valid), .bad_o(rx_bad));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic set_gas(input logic [15:0] v, input int n, input logic [2:0] e);
    gas = v;
    cyc(n);
    chk(alarm, e);
  endtask
  task automatic wr_cfg(input logic [1:0] c, input logic [15:0] t, input logic [7:0] d);
    ch = c; thr = t; dwell = d; we = 1'b1;
    cyc(1);
    we = 1'b0;
    cyc(1);
  endtask
  task automatic count_hi(input int n);
    hi = 0;
    repeat (n) begin
      @(negedge clk_i);
      hi += (contact[0] === 1'b1);
    end
  endtask
  // A second start in mid-frame must be dropped, so only one frame is expected.
  task automatic send(input logic [7:0] e);
    exp_q.push_back(e);
    tx_start = 1'b1; cyc(1); tx_start = 1'b0;
    cyc(3 * BC);
    tx_start = 1'b1; cyc(1); tx_start = 1'b0;
    cyc(12 * BC);
    chk({tx_en, tx}, 2'h1);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clk_i) begin
    if (rx_valid === 1'b1) begin
      chk(rx_byte, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);
      chk(rx_bad, 1'b0);
    end
  end
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    #(30000 * 10);
    fail_count++;
    tally_and_finish();
  end
  initial begin
    rst_i = 1'b1; gv = 0; fi = 0; we = 0; done = 0; latch = 0; rkey = 0; buzz = 0;
    nv_valid = 0; nv_last = 0; nv_word = 0; nv_sum = 0; tx_start = 0; ch = 0; thr = 0;
    dwell = 8'h01; gas = 0; adc = 16'h8000; sup = 16'h5DC0; hs = 16'h0064;
    low = 0; cen = 0; ben = 0; db = '0; rs = 32'd76372;
    cyc(3);
    rst_i = 1'b0;
    chk({alarm, contact, fault, msg, tx}, 16'h0001);
    fi = 1'b1; cyc(1); fi = 1'b0;
    set_gas(16'h0013, TW, 3'h0);
    set_gas(16'h0014, TW, 3'h1);
    set_gas(16'h0028, TW, 3'h3);
    set_gas(16'h0032, TW, 3'h7);
    set_gas(16'h0000, 3, 3'h0);
    wr_cfg(2'h0, 16'h00C8, 8'h01);
    wr_cfg(2'h3, 16'h0000, 8'h01);
    set_gas(16'h0063, TW, 3'h6);
    set_gas(16'h0064, TW, 3'h7);
    db[1] = 16'h0005; db[2] = 16'h0005; low = 3'h4;
    set_gas(16'h002E, TW, 3'h2);
    set_gas(16'h002D, TW, 3'h6);
    set_gas(16'h002C, TW, 3'h4);
    db = '0; low = 3'h0;
    wr_cfg(2'h0, 16'h0014, 8'h03);
    set_gas(16'h0000, 3, 3'h0);
    // Each excursion may hold three ticks, still short of a three second dwell.
    repeat (2) begin
      set_gas(16'h0014, 3 * SC - 2, 3'h0);
      set_gas(16'h0000, 2, 3'h0);
    end
    set_gas(16'h0014, 4 * SC + 4, 3'h1);
    cyc(3); chk(contact, 3'h0);
    cen = 3'h7; cyc(3); chk(contact, 3'h1);
    cen = 3'h0; ben = 3'h7; buzz = 1'b1;
    count_hi(2 * SC); chk(16'(hi), 16'h0000);
    cen = 3'h7;
    count_hi(4 * SC); chk(hi >= SC && hi <= 3 * SC, 1'b1);
    buzz = 1'b0; ben = 3'h0; latch = 1'b1;
    set_gas(16'h0000, 5, 3'h1);
    rkey = 1'b1; cyc(2); chk(alarm, 3'h0);
    rkey = 1'b0; latch = 1'b0;
    done = 1'b1; cyc(1); done = 1'b0;
    hi = 0;
    repeat (2 * SC + 5) begin
      hi += (msg === 1'b1);
      cyc(1);
    end
    chk(16'(hi), 16'(2 * SC));
    for (int i = 0; i < 5; i++) begin
      adc = av[i]; sup = sv[i]; cyc(2);
      chk(fault, fv[i]);
    end
    sup = 16'h5DC0;
    for (int k = 0; k < 2; k++) begin
      hi = 0;
      for (int i = 0; i < 4; i++) begin
        rs = lfsr(rs);
        hi += rs[7:0];
        nv_word = rs[7:0];
        nv_sum = 8'(hi) ^ {7'h00, k == 0 && i == 3};
        nv_valid = 1'b1; nv_last = (i == 3); cyc(1);
      end
      nv_valid = 1'b0; nv_last = 1'b0; cyc(3);
      chk(fault, (k == 0) ? 5'h04 : 5'h00);
    end
    for (int i = 0; i < 16; i++) begin
      gas = i[0] ? 16'h001E : 16'h000A; gv = 1'b1; cyc(1);
    end
    gv = 1'b0; gas = 16'h0000; cyc(3);
    chk(fault, 5'h10);
    cyc(2 * SC + 4); chk(fault, 5'h00);
    set_gas(16'h0000, 3, 3'h0);
    send(8'h00);
    adc = 16'hFFF0;
    set_gas(16'h0032, 4 * SC + 4, 3'h7);
    send(8'h0F);
    cyc(4); chk(16'(exp_q.size()), 16'h0000);
    tally_and_finish();
  end
endmodule
